// file: pkg/cfg_loader_pkg.sv
// Purpose: Shared constants, types and helpers for the serial configuration memory readout.
// Assumes: 16-bit stored words, 20-bit word address, 200 MHz system clock.
// Notes: Link-side logic runs on the serial configuration clock.
////////////////////////////////////////////////////////////////////////////////
package cfg_loader_pkg;

    localparam int ADDR_W = 20;
    localparam int WORD_W = 16;
    localparam int BIT_W = 4;

    localparam logic [ADDR_W-1:0] ADDR_RESET = 20'h0_0000;
    localparam logic [ADDR_W-1:0] ADDR_TOP = 20'hF_FFFF;
    localparam logic [17:0] PAGE_OFS_MIN = 18'h0_0000;
    localparam logic [17:0] PAGE_OFS_MAX = 18'h3_FFFF;
    localparam logic [BIT_W-1:0] BIT_RESET = 4'h0;
    localparam logic [BIT_W-1:0] BIT_LAST = 4'hF;

    // Power-on reset hold time and its cycle count, rounded up
    localparam int POR_TIME_NS = 1000;
    localparam int SYS_CLK_MHZ = 200;
    localparam int POR_CYCLES = (POR_TIME_NS * SYS_CLK_MHZ + 999) / 1000;
    localparam int POR_CNT_W = 8;
    localparam logic [POR_CNT_W-1:0] POR_CNT_RESET = 8'h00;
    localparam logic [POR_CNT_W-1:0] POR_LAST = POR_CNT_W'(POR_CYCLES - 1);

    typedef enum logic [3:0] {
        CASC_IDLE = 4'h1,
        CASC_HOLD = 4'h2,
        CASC_FOLLOW = 4'h4,
        CASC_DONE = 4'h8
    } casc_state_t;

    typedef struct packed {
        logic serial_enable_config_mode;
        logic chip_select_low;
        logic outEnable;
        logic pageEnable;
        logic [1:0] page_select;
        logic program_device_select;
    } cfg_pins_t;

    typedef struct packed {
        logic en;
        logic [ADDR_W-1:0] addr;
        logic [WORD_W-1:0] data;
    } prog_write_t;

    function automatic logic [ADDR_W-1:0] pageBase(input logic en, input logic [1:0] sel);
        pageBase = en ? {sel, PAGE_OFS_MIN} : ADDR_RESET;
    endfunction

    function automatic logic [ADDR_W-1:0] pageTop(input logic en, input logic [1:0] sel);
        pageTop = en ? {sel, PAGE_OFS_MAX} : ADDR_TOP;
    endfunction

endpackage

// file: tb/loader_partner.sv
// Purpose: Loading device that clocks the configuration stream in.
// Assumes: Its serial clock stands still outside frames.
// Notes: The data pin has a pull-up; undriven it reads high.
////////////////////////////////////////////////////////////////////////////////
`timescale 1ns/1ps
module loader_partner (
    input wire logic dataOut,
    input wire logic dataOe,
    output logic linkClk,
    output logic [15:0] captured
);
    logic lastBit;

    initial begin
        linkClk = 1'b0;
        captured = 16'h0000;
        lastBit = 1'b0;
    end

    // Sampled on the falling edge, LSB first; take=0 lets bits pass unused
    task automatic pulses(input int n, input bit take);
        for (int i = 0; i < n; i++) begin
            #1.3 linkClk = 1'b1;
            #3 linkClk = 1'b0;
            lastBit = dataOe ? dataOut : 1'b1;
            if (take) captured = {lastBit, captured[15:1]};
            #1.7;
        end
    endtask
endmodule

// file: tb/serial_config_memory_readout_tb_top.sv
// Purpose: Self-checking bench for the configuration memory readout.
// Assumes: Link sync takes two serial edges; sys outputs settle within six cycles.
// Notes: Full page reads are too long to run, so the end-of-memory cascade is not reached.
////////////////////////////////////////////////////////////////////////////////
`timescale 1ns/1ps
module serial_config_memory_readout_tb_top;
    import cfg_loader_pkg::*;

    logic sys_clk;
    logic nrst;
    logic linkClk;
    cfg_pins_t pins;
    prog_write_t progWrite;
    logic dataOut;
    logic dataOe;
    logic cascOutLow;
    logic readyOut;
    logic readyOe;
    logic readyPin;
    logic [15:0] captured;
    logic [15:0] pageWord [4] = '{16'hA5C3, 16'h1234, 16'h8001, 16'h7E5A};
    logic [15:0] word1 = 16'h0F1E;
    int n_mismatch = 0;
    int check_count = 0;
    int cycles = 0;

    // Open-collector ready line with its pull-up
    assign readyPin = readyOe ? readyOut : 1'b1;

    serial_config_memory_readout uut (
        .sys_clk(sys_clk),
        .nrst(nrst),
        .serial_config_clock(linkClk),
        .pins(pins),
        .progWrite(progWrite),
        .dataOut(dataOut),
        .dataOe(dataOe),
        .cascade_select_out_low(cascOutLow),
        .readyOut(readyOut),
        .readyOe(readyOe)
    );

    loader_partner fpga (
        .dataOut(dataOut),
        .dataOe(dataOe),
        .linkClk(linkClk),
        .captured(captured)
    );

    initial begin
        sys_clk = 1'b0;
        forever #2.5 sys_clk = ~sys_clk;
    end

    ////////////////////////////////////////////////////////////////////////////////
    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", check_count, n_mismatch);
        if (n_mismatch == 0 && check_count > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask

    always @(posedge sys_clk) begin
        cycles++;
        if (cycles == 20000) begin
            n_mismatch++;
            tally_and_finish();
        end
    end

    task automatic chk(input string nm, input logic [15:0] exp, input logic [15:0] got);
        check_count++;
        if (got !== exp) begin
            n_mismatch++;
            $display("unexpected %s: expected %h seen %h", nm, exp, got);
        end
    endtask

    function automatic cfg_pins_t mk(input logic se, input logic cs, input logic oe, input logic pe,
                                     input logic [1:0] ps, input logic pd);
        mk = '{se, cs, oe, pe, ps, pd};
    endfunction

    // Long enough for the two-flop sync plus the output register
    task automatic drive(input cfg_pins_t p);
        @(posedge sys_clk);
        pins <= p;
        repeat (6) @(posedge sys_clk);
    endtask

    task automatic progW(input logic [19:0] a, input logic [15:0] d, input cfg_pins_t p);
        drive(p);
        fpga.pulses(3, 1'b0);
        @(posedge sys_clk);
        progWrite <= '{1'b1, a, d};
        @(posedge sys_clk);
        fpga.pulses(1, 1'b0);
        @(posedge sys_clk);
        progWrite.en <= 1'b0;
    endtask

    // Clear the counters, then enable; two edges pass before the first bit
    task automatic loadFrom(input cfg_pins_t p);
        p.outEnable = 1'b0;
        drive(p);
        fpga.pulses(4, 1'b0);
        chk("dataOe while cleared", 16'h0000, dataOe);
        p.outEnable = 1'b1;
        drive(p);
        fpga.pulses(2, 1'b0);
        chk("dataOe when enabled", 16'h0001, dataOe);
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        nrst = 1'b0;
        pins = mk(1'b1, 1'b1, 1'b1, 1'b0, 2'b00, 1'b0);
        progWrite = '0;
        repeat (5) @(posedge sys_clk);
        chk("dataOe in reset", 16'h0000, dataOe);
        chk("ready in reset", 16'h0000, readyPin);
        chk("cascade in reset", 16'h0001, cascOutLow);
        nrst <= 1'b1;
        repeat (5) @(posedge sys_clk);
        chk("ready early", 16'h0000, readyPin);
        // The serial clock must tick during power-on reset for the counters to clear
        fpga.pulses(4, 1'b0);
        chk("dataOut after power-up", 16'h0000, dataOut);
        repeat (220) @(posedge sys_clk);
        chk("ready released", 16'h0001, readyPin);
        fpga.pulses(4, 1'b0);
        progW(20'h0_0000, pageWord[0], mk(1'b0, 1'b1, 1'b1, 1'b0, 2'b00, 1'b1));
        progW(20'h0_0001, word1, mk(1'b0, 1'b0, 1'b1, 1'b0, 2'b00, 1'b1));
        for (int pg = 1; pg < 4; pg++) begin
            progW({2'(pg), 18'h0_0000}, pageWord[pg], mk(1'b0, 1'b1, 1'b1, 1'b0, 2'b00, 1'b1));
        end
        progW(20'h4_0000, 16'hFFFF, mk(1'b0, 1'b1, 1'b1, 1'b0, 2'b00, 1'b0));
        progW(20'h8_0000, 16'hFFFF, mk(1'b1, 1'b1, 1'b1, 1'b0, 2'b00, 1'b1));
        drive(mk(1'b0, 1'b0, 1'b1, 1'b0, 2'b00, 1'b0));
        chk("dataOe programming mode", 16'h0000, dataOe);
        // Page select ignored while paging is off
        loadFrom(mk(1'b1, 1'b0, 1'b1, 1'b0, 2'b11, 1'b0));
        fpga.pulses(8, 1'b1);
        chk("low byte", {8'h00, pageWord[0][7:0]}, {8'h00, captured[15:8]});
        drive(mk(1'b1, 1'b1, 1'b1, 1'b0, 2'b11, 1'b0));
        chk("dataOe standby", 16'h0000, dataOe);
        // Two bits slip by before the sync sees the deselect
        fpga.pulses(8, 1'b0);
        drive(mk(1'b1, 1'b0, 1'b1, 1'b0, 2'b11, 1'b0));
        fpga.pulses(2, 1'b0);
        fpga.pulses(6, 1'b1);
        chk("resumed bits", {10'h000, pageWord[0][15:10]}, {10'h000, captured[15:10]});
        fpga.pulses(16, 1'b1);
        chk("next word", word1, captured);
        chk("cascade before top", 16'h0001, cascOutLow);
        for (int pg = 0; pg < 4; pg++) begin
            loadFrom(mk(1'b1, 1'b0, 1'b1, 1'b1, 2'(pg), 1'b0));
            fpga.pulses(16, 1'b1);
            chk("page base word", pageWord[pg], captured);
        end
        tally_and_finish();
    end
endmodule

// file: verilog/bit_sync2.sv
// Purpose: Two-flop synchroniser for levels entering a clock domain.
// Assumes: Each bit is an independent slow level.
// Notes: The first flop is read only by the second.
////////////////////////////////////////////////////////////////////////////////
`timescale 1ns/1ps
module bit_sync2 #(
    parameter int W = 1
) (
    input wire logic clk,
    input wire logic [W-1:0] asyncIn,
    output logic [W-1:0] synced
);
    logic [W-1:0] meta_r;

    always_ff @(posedge clk) begin
        meta_r <= asyncIn;
        synced <= meta_r;
    end
endmodule

// file: verilog/config_bit_array.sv
// Purpose: Storage array for the configuration bitstream.
// Assumes: Written one word at a time by the programming path on the link clock.
// Notes: Asynchronous read so the bit counter sees the current word at once.
////////////////////////////////////////////////////////////////////////////////
`timescale 1ns/1ps
module config_bit_array
    import cfg_loader_pkg::*;
(
    input wire logic clk,
    input wire logic wrEn,
    input wire logic [cfg_loader_pkg::ADDR_W-1:0] wrAddr,
    input wire logic [cfg_loader_pkg::WORD_W-1:0] wrData,
    input wire logic [cfg_loader_pkg::ADDR_W-1:0] rdAddr,
    output logic [cfg_loader_pkg::WORD_W-1:0] rdWord
);
    logic [WORD_W-1:0] mem [0:(1 << ADDR_W)-1];

    always_ff @(posedge clk) begin
        if (wrEn) begin
            mem[wrAddr] <= wrData;
        end
    end

    assign rdWord = mem[rdAddr];
endmodule

// file: verilog/serial_config_memory_readout.sv
// Purpose: Readout control of a serial configuration memory feeding a loading device.
// Assumes: Pins are asynchronous to both clocks; the loading device drives the serial clock.
// Notes: Counters live on the serial clock; pin gating and ready live on sys_clk.
////////////////////////////////////////////////////////////////////////////////
`timescale 1ns/1ps
module serial_config_memory_readout (
    input wire logic sys_clk,
    input wire logic nrst,
    input wire logic serial_config_clock,
    input wire cfg_loader_pkg::cfg_pins_t pins,
    input wire cfg_loader_pkg::prog_write_t progWrite,
    output logic dataOut,
    output logic dataOe,
    output logic cascade_select_out_low,
    output logic readyOut,
    output logic readyOe
);
    import cfg_loader_pkg::*;

    ////////////////////////////////////////////////////////////////////////////
    // Crossings
    // Each domain resynchronises the pins itself; page select is read only while static
    cfg_pins_t pinS;
    cfg_pins_t pinL;
    logic maxS;
    logic porDoneL;
    logic linkRst;

    logic [POR_CNT_W-1:0] porCnt_r;
    logic [POR_CNT_W-1:0] porCnt_nxt;
    logic porDone_r;
    logic porDone_nxt;
    logic readyOe_r;
    logic readyOe_nxt;
    casc_state_t cascState_r;
    casc_state_t cascState_nxt;
    logic cascOut_r;
    logic cascOut_nxt;
    logic dataOe_r;
    logic dataOe_nxt;

    logic [ADDR_W-1:0] addr_r;
    logic [ADDR_W-1:0] addr_nxt;
    logic [BIT_W-1:0] bit_r;
    logic [BIT_W-1:0] bit_nxt;
    logic reachedMax_r;
    logic reachedMax_nxt;
    logic dataBit_r;
    logic dataBit_nxt;
    logic [ADDR_W-1:0] topAddr;
    logic advance;
    logic memWrEn;
    logic [WORD_W-1:0] rdWord;

    bit_sync2 #(.W($bits(cfg_pins_t))) u_pin_sys (
        .clk(sys_clk),
        .asyncIn(pins),
        .synced(pinS)
    );

    bit_sync2 #(.W($bits(cfg_pins_t))) u_pin_link (
        .clk(serial_config_clock),
        .asyncIn(pins),
        .synced(pinL)
    );

    bit_sync2 #(.W(1)) u_max_sys (
        .clk(sys_clk),
        .asyncIn(reachedMax_r),
        .synced(maxS)
    );

    bit_sync2 #(.W(1)) u_por_link (
        .clk(serial_config_clock),
        .asyncIn(porDone_r),
        .synced(porDoneL)
    );

    // Link side held in reset until power-on reset has finished
    // Limitation: counters clear only if the serial clock ticks during power-on reset
    assign linkRst = !porDoneL;

    ////////////////////////////////////////////////////////////////////////////
    // Power-on reset and ready pin
    always_comb begin
        porCnt_nxt = porCnt_r;
        porDone_nxt = porDone_r;
        if (!nrst) begin
            porCnt_nxt = POR_CNT_RESET;
            porDone_nxt = 1'b0;
        end else if (!porDone_r) begin
            if (porCnt_r == POR_LAST) begin
                porDone_nxt = 1'b1;
            end else begin
                porCnt_nxt = porCnt_r + 1'b1;
            end
        end
        readyOe_nxt = !porDone_nxt;
    end

    always_ff @(posedge sys_clk) begin
        porCnt_r <= porCnt_nxt;
        porDone_r <= porDone_nxt;
        readyOe_r <= readyOe_nxt;
    end

    assign readyOut = 1'b0;
    assign readyOe = readyOe_r;

    ready_during_por_a: assert property (@(posedge sys_clk) disable iff (!nrst)
        !porDone_r |-> readyOe_r)
        else $error("ready released before power-on reset finished");

    ready_released_a: assert property (@(posedge sys_clk) disable iff (!nrst)
        $rose(porDone_r) |-> !readyOe_r && $past(porCnt_r) == POR_LAST)
        else $error("ready not released at end of power-on reset");

    por_latch_a: assert property (@(posedge sys_clk) disable iff (!nrst)
        porDone_r |=> porDone_r && !readyOe_r)
        else $error("ready pulled low again without a reset");

    ////////////////////////////////////////////////////////////////////////////
    // Cascade select and data pin enable
    always_comb begin
        cascState_nxt = cascState_r;
        case (cascState_r)
            CASC_IDLE: begin
                if (maxS) begin
                    cascState_nxt = CASC_HOLD;
                end
            end
            CASC_HOLD: begin
                if (!pinS.outEnable) begin
                    cascState_nxt = CASC_DONE;
                end else if (pinS.chip_select_low) begin
                    cascState_nxt = CASC_FOLLOW;
                end
            end
            CASC_FOLLOW: begin
                if (!pinS.outEnable) begin
                    cascState_nxt = CASC_DONE;
                end
            end
            CASC_DONE: begin
                // Stays high until the counters restart and reach the top again
                if (!maxS) begin
                    cascState_nxt = CASC_IDLE;
                end
            end
            default: begin
                cascState_nxt = CASC_IDLE;
            end
        endcase
        if (!nrst || !pinS.serial_enable_config_mode) begin
            cascState_nxt = CASC_IDLE;
        end
        case (cascState_nxt)
            CASC_HOLD: cascOut_nxt = 1'b0;
            CASC_FOLLOW: cascOut_nxt = pinS.chip_select_low;
            default: cascOut_nxt = 1'b1;
        endcase
        // Chip select only gates the pin in configuration mode
        dataOe_nxt = nrst && porDone_r && pinS.serial_enable_config_mode
            && pinS.outEnable && !pinS.chip_select_low
            && cascState_r == CASC_IDLE;
    end

    always_ff @(posedge sys_clk) begin
        cascState_r <= cascState_nxt;
        cascOut_r <= cascOut_nxt;
        dataOe_r <= dataOe_nxt;
    end

    assign cascade_select_out_low = cascOut_r;
    assign dataOe = dataOe_r;

    drive_gate_a: assert property (@(posedge sys_clk) disable iff (!nrst)
        dataOe_r |-> $past(pinS.outEnable) && !$past(pinS.chip_select_low)
            && $past(pinS.serial_enable_config_mode))
        else $error("data pin driven without enable and select");

    casc_low_a: assert property (@(posedge sys_clk) disable iff (!nrst)
        cascState_r == CASC_IDLE && maxS && pinS.serial_enable_config_mode |=> !cascOut_r)
        else $error("cascade select not low after maximum");

    follow_cs_a: assert property (@(posedge sys_clk) disable iff (!nrst)
        cascState_r == CASC_FOLLOW && pinS.outEnable && pinS.serial_enable_config_mode
            |=> cascOut_r == $past(pinS.chip_select_low))
        else $error("cascade select does not follow chip select");

    casc_done_a: assert property (@(posedge sys_clk) disable iff (!nrst)
        cascState_r == CASC_DONE && maxS |=> cascOut_r)
        else $error("cascade select not high after output enable fell");

    no_contend_a: assert property (@(posedge sys_clk) disable iff (!nrst)
        cascState_r != CASC_IDLE |=> !dataOe_r)
        else $error("data pin driven after stream exhausted");

    casc_idle_a: assert property (@(posedge sys_clk) disable iff (!nrst)
        cascState_r == CASC_IDLE && !maxS |=> cascOut_r)
        else $error("cascade select low before the top address");

    ////////////////////////////////////////////////////////////////////////////
    // Address and bit counters on the serial clock
    assign topAddr = pageTop(pinL.pageEnable, pinL.page_select);
    // Standby: chip select high freezes the counters, but output enable low still reloads them
    assign advance = pinL.serial_enable_config_mode && pinL.outEnable
        && !pinL.chip_select_low && !reachedMax_r;

    always_comb begin
        addr_nxt = addr_r;
        bit_nxt = bit_r;
        reachedMax_nxt = reachedMax_r;
        dataBit_nxt = dataBit_r;
        if (linkRst) begin
            addr_nxt = ADDR_RESET;
            bit_nxt = BIT_RESET;
            reachedMax_nxt = 1'b0;
            dataBit_nxt = 1'b0;
        end else if (pinL.serial_enable_config_mode && !pinL.outEnable) begin
            // Reload at the page base so a paged load starts in its page
            addr_nxt = pageBase(pinL.pageEnable, pinL.page_select);
            bit_nxt = BIT_RESET;
            reachedMax_nxt = 1'b0;
        end else if (advance) begin
            dataBit_nxt = rdWord[bit_r];
            if (bit_r == BIT_LAST) begin
                bit_nxt = BIT_RESET;
                if (addr_r == topAddr) begin
                    reachedMax_nxt = 1'b1;
                end else begin
                    addr_nxt = addr_r + 1'b1;
                end
            end else begin
                bit_nxt = bit_r + 1'b1;
            end
        end
    end

    always_ff @(posedge serial_config_clock) begin
        addr_r <= addr_nxt;
        bit_r <= bit_nxt;
        reachedMax_r <= reachedMax_nxt;
        dataBit_r <= dataBit_nxt;
    end

    assign dataOut = dataBit_r;

    // Programming writes only with the programming select, never via chip select
    assign memWrEn = progWrite.en && !pinL.serial_enable_config_mode
        && pinL.program_device_select;

    config_bit_array u_array (
        .clk(serial_config_clock),
        .wrEn(memWrEn),
        .wrAddr(progWrite.addr),
        .wrData(progWrite.data),
        .rdAddr(addr_r),
        .rdWord(rdWord)
    );

    ctr_reset_a: assert property (@(posedge serial_config_clock) disable iff (linkRst)
        pinL.serial_enable_config_mode && !pinL.outEnable
            |=> bit_r == BIT_RESET && !reachedMax_r
            && addr_r == pageBase($past(pinL.pageEnable), $past(pinL.page_select)))
        else $error("counters not reset by output enable low");

    bit_advance_a: assert property (@(posedge serial_config_clock) disable iff (linkRst)
        advance && bit_r != BIT_LAST
            |=> bit_r == $past(bit_r) + 1'b1 && dataBit_r == $past(rdWord[bit_r]))
        else $error("bit counter did not advance");

    standby_hold_a: assert property (@(posedge serial_config_clock) disable iff (linkRst)
        pinL.serial_enable_config_mode && pinL.outEnable && pinL.chip_select_low
            |=> $stable(addr_r) && $stable(bit_r))
        else $error("counters moved in standby");

    prog_ignore_a: assert property (@(posedge serial_config_clock) disable iff (linkRst)
        !pinL.serial_enable_config_mode |=> $stable(addr_r) && $stable(bit_r))
        else $error("counters moved in programming mode");

    prog_select_a: assert property (@(posedge serial_config_clock) disable iff (linkRst)
        memWrEn |-> pinL.program_device_select && !pinL.serial_enable_config_mode)
        else $error("array written without programming select");

    page_top_a: assert property (@(posedge serial_config_clock) disable iff (linkRst)
        $rose(reachedMax_r) |-> addr_r == pageTop($past(pinL.pageEnable), $past(pinL.page_select)))
        else $error("stream ended away from the selected top address");

    word_carry_a: assert property (@(posedge serial_config_clock) disable iff (linkRst)
        advance && bit_r == BIT_LAST && addr_r != topAddr
            |=> addr_r == $past(addr_r) + 1'b1 && bit_r == BIT_RESET)
        else $error("bit counter wrap did not carry into address");

    por_link_a: assert property (@(posedge serial_config_clock)
        linkRst |=> addr_r == ADDR_RESET && bit_r == BIT_RESET && !reachedMax_r)
        else $error("counters not cleared by power-on reset");

    // A stalled stream must keep its last bit so the loader never sees a glitch
    data_hold_a: assert property (@(posedge serial_config_clock) disable iff (linkRst)
        !advance |=> $stable(dataBit_r))
        else $error("data bit changed without an advancing clock");

endmodule
